// [design/sync_io_pkg.sv]
`default_nettype none
package sync_io_pkg;

  localparam int CLK_HZ       = 20_000_000;
  localparam int PULSE_LOW_US = 30;
  // Least time, so round up to whole cycles
  localparam int PULSE_CYC    = (PULSE_LOW_US * CLK_HZ + 999_999) / 1_000_000;

  localparam int NUM_LINES = 2;
  localparam int ADDR_W    = 8;
  localparam int CNT_W     = 10;
  localparam int PWM_W     = 24;
  localparam int CFG_W     = 5;

  localparam logic [CNT_W-1:0] PULSE_CNT = CNT_W'(PULSE_CYC);

  // Register byte offsets
  localparam logic [ADDR_W-1:0] ADDR_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_CFG0   = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_CFG1   = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_PER0   = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_DUTY0  = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_PER1   = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_DUTY1  = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h1C;

  // Field positions
  localparam int CTRL_SET_BIT  = 0;
  localparam int CTRL_CLR_BIT  = 1;
  localparam int CFG_INV_BIT   = 0;
  localparam int CFG_FUNC_LSB  = 1;
  localparam int CFG_OSEL_LSB  = 3;

  // Values after reset
  localparam logic [CFG_W-1:0] CFG_RST  = 5'h00;
  localparam logic [PWM_W-1:0] PER_RST  = 24'h000000;
  localparam logic [PWM_W-1:0] DUTY_RST = 24'h000000;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    FUNC_SYNC   = 2'h0,
    FUNC_INPUT  = 2'h1,
    FUNC_OUTPUT = 2'h2
  } line_func_e;

  typedef enum logic [1:0] {
    OSEL_FALSE = 2'h0,
    OSEL_TRUE  = 2'h1,
    OSEL_PWM   = 2'h2
  } out_sel_e;

endpackage : sync_io_pkg
`default_nettype wire

// [design/sync_on_off_pulse_io.sv]
// Implementation choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module sync_on_off_pulse_io
(
  input  wire logic                             aclk,
  input  wire logic                             aresetn,
  input  wire logic [sync_io_pkg::ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                             s_axi_awvalid,
  output logic                                  s_axi_awready,
  input  wire logic [31:0]                      s_axi_wdata,
  input  wire logic [3:0]                       s_axi_wstrb,
  input  wire logic                             s_axi_wvalid,
  output logic                                  s_axi_wready,
  output logic [1:0]                            s_axi_bresp,
  output logic                                  s_axi_bvalid,
  input  wire logic                             s_axi_bready,
  input  wire logic [sync_io_pkg::ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                             s_axi_arvalid,
  output logic                                  s_axi_arready,
  output logic [31:0]                           s_axi_rdata,
  output logic [1:0]                            s_axi_rresp,
  output logic                                  s_axi_rvalid,
  input  wire logic                             s_axi_rready,
  input  wire logic [sync_io_pkg::NUM_LINES-1:0] sync_in,
  output logic [sync_io_pkg::NUM_LINES-1:0]     sync_out,
  output logic [sync_io_pkg::NUM_LINES-1:0]     sync_oe,
  output logic [sync_io_pkg::NUM_LINES-1:0]     line_level,
  output logic                                  load_enable
);
  import sync_io_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [ADDR_W-1:0]    awaddr_reg;
  logic                 aw_have_reg;
  logic [31:0]          wdata_reg;
  logic [3:0]           wstrb_reg;
  logic                 w_have_reg;
  logic                 bvalid_reg;
  logic [1:0]           bresp_reg;
  logic                 rvalid_reg;
  logic [1:0]           rresp_reg;
  logic [31:0]          rdata_reg;

  logic                 wr_fire;
  logic [31:0]          wmask;
  logic                 wr_ok;
  logic                 wsel_ctrl;
  logic [NUM_LINES-1:0] wsel_cfg;
  logic [NUM_LINES-1:0] wsel_per;
  logic [NUM_LINES-1:0] wsel_duty;
  logic                 rd_ok;
  logic [31:0]          rd_value;

  logic [CFG_W-1:0]     cfg_reg  [NUM_LINES];
  logic [PWM_W-1:0]     per_reg  [NUM_LINES];
  logic [PWM_W-1:0]     duty_reg [NUM_LINES];

  logic                 load_enable_reg;
  logic                 load_enable_next;
  logic                 sw_set;
  logic                 sw_clr;
  logic [NUM_LINES-1:0] tx_start;
  logic [NUM_LINES-1:0] rx_accept;
  logic [NUM_LINES-1:0] tx_busy;
  logic [NUM_LINES-1:0] sync_s1_reg;
  logic [NUM_LINES-1:0] sync_s2_reg;
  logic [NUM_LINES-1:0] level_reg;
  logic [NUM_LINES-1:0] out_reg;
  logic [NUM_LINES-1:0] oe_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Byte enables widened to a bit mask
  function automatic logic [31:0] strb_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = 32'h00000000;
    for (int b = 0; b < 4; b++)
    begin
      m[b*8 +: 8] = {8{strb[b]}};
    end
    return m;
  endfunction : strb_mask

  // Word-aligned view of a byte address
  function automatic logic [ADDR_W-1:0] word_addr(input logic [ADDR_W-1:0] a);
    return {a[ADDR_W-1:2], 2'b00};
  endfunction : word_addr

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path

  assign s_axi_awready = ~aw_have_reg;
  assign s_axi_wready  = ~w_have_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  // Commit only when both halves are held and no response is pending
  assign wr_fire       = aw_have_reg & w_have_reg & ~bvalid_reg;
  assign wmask         = strb_mask(wstrb_reg);

  // Address and data accepted in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_reg <= 1'b0;
      awaddr_reg  <= '0;
    end
    else if (s_axi_awvalid && !aw_have_reg)
    begin
      aw_have_reg <= 1'b1;
      awaddr_reg  <= s_axi_awaddr;
    end
    else if (wr_fire)
    begin
      aw_have_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_have_reg <= 1'b0;
      wdata_reg  <= 32'h00000000;
      wstrb_reg  <= 4'h0;
    end
    else if (s_axi_wvalid && !w_have_reg)
    begin
      w_have_reg <= 1'b1;
      wdata_reg  <= s_axi_wdata;
      wstrb_reg  <= s_axi_wstrb;
    end
    else if (wr_fire)
    begin
      w_have_reg <= 1'b0;
    end
  end

  // Response held until the master takes it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
    begin
      bvalid_reg <= 1'b0;
    end
  end

  // Write address decode
  always_comb
  begin
    wsel_ctrl = 1'b0;
    wsel_cfg  = '0;
    wsel_per  = '0;
    wsel_duty = '0;
    wr_ok     = 1'b1;
    if (word_addr(awaddr_reg) == ADDR_CTRL)
      wsel_ctrl = 1'b1;
    else if (word_addr(awaddr_reg) == ADDR_CFG0)
      wsel_cfg[0] = 1'b1;
    else if (word_addr(awaddr_reg) == ADDR_CFG1)
      wsel_cfg[1] = 1'b1;
    else if (word_addr(awaddr_reg) == ADDR_PER0)
      wsel_per[0] = 1'b1;
    else if (word_addr(awaddr_reg) == ADDR_DUTY0)
      wsel_duty[0] = 1'b1;
    else if (word_addr(awaddr_reg) == ADDR_PER1)
      wsel_per[1] = 1'b1;
    else if (word_addr(awaddr_reg) == ADDR_DUTY1)
      wsel_duty[1] = 1'b1;
    else if (word_addr(awaddr_reg) == ADDR_STATUS)
      wr_ok = 1'b1;          // Read-only, write ignored
    else
      wr_ok = 1'b0;
  end

  // Line configuration registers with byte enables
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < NUM_LINES; i++)
      begin
        cfg_reg[i]  <= CFG_RST;
        per_reg[i]  <= PER_RST;
        duty_reg[i] <= DUTY_RST;
      end
    end
    else if (wr_fire)
    begin
      for (int i = 0; i < NUM_LINES; i++)
      begin
        if (wsel_cfg[i])
          cfg_reg[i] <= (cfg_reg[i] & ~wmask[CFG_W-1:0])
                        | (wdata_reg[CFG_W-1:0] & wmask[CFG_W-1:0]);
        if (wsel_per[i])
          per_reg[i] <= (per_reg[i] & ~wmask[PWM_W-1:0])
                        | (wdata_reg[PWM_W-1:0] & wmask[PWM_W-1:0]);
        if (wsel_duty[i])
          duty_reg[i] <= (duty_reg[i] & ~wmask[PWM_W-1:0])
                         | (wdata_reg[PWM_W-1:0] & wmask[PWM_W-1:0]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path

  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  // Read address decode; unused bits read as zero
  always_comb
  begin
    rd_value = 32'h00000000;
    rd_ok    = 1'b1;
    if (word_addr(s_axi_araddr) == ADDR_CTRL)
      rd_value[0] = load_enable_reg;
    else if (word_addr(s_axi_araddr) == ADDR_CFG0)
      rd_value[CFG_W-1:0] = cfg_reg[0];
    else if (word_addr(s_axi_araddr) == ADDR_CFG1)
      rd_value[CFG_W-1:0] = cfg_reg[1];
    else if (word_addr(s_axi_araddr) == ADDR_PER0)
      rd_value[PWM_W-1:0] = per_reg[0];
    else if (word_addr(s_axi_araddr) == ADDR_DUTY0)
      rd_value[PWM_W-1:0] = duty_reg[0];
    else if (word_addr(s_axi_araddr) == ADDR_PER1)
      rd_value[PWM_W-1:0] = per_reg[1];
    else if (word_addr(s_axi_araddr) == ADDR_DUTY1)
      rd_value[PWM_W-1:0] = duty_reg[1];
    else if (word_addr(s_axi_araddr) == ADDR_STATUS)
      rd_value[4:0] = {tx_busy, level_reg, load_enable_reg};
    else
      rd_ok = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= RESP_OKAY;
      rdata_reg  <= 32'h00000000;
    end
    else if (s_axi_arvalid && !rvalid_reg)
    begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      rdata_reg  <= rd_value;
    end
    else if (s_axi_rready)
    begin
      rvalid_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Load input enable

  // Clear beats set when software writes both at once, the safe side
  assign sw_set = wr_fire & wsel_ctrl & wmask[CTRL_SET_BIT]
                  & wdata_reg[CTRL_SET_BIT] & ~wdata_reg[CTRL_CLR_BIT];
  assign sw_clr = wr_fire & wsel_ctrl & wmask[CTRL_CLR_BIT]
                  & wdata_reg[CTRL_CLR_BIT];

  // Only local changes start a pulse, so partners never echo back
  assign tx_start[0] = sw_set & ~load_enable_reg;
  assign tx_start[1] = sw_clr & load_enable_reg;

  always_comb
  begin
    load_enable_next = load_enable_reg;
    if (rx_accept[0] && !load_enable_reg)
      load_enable_next = 1'b1;
    if (rx_accept[1] && load_enable_reg)
      load_enable_next = 1'b0;
    if (sw_set)
      load_enable_next = 1'b1;
    if (sw_clr)
      load_enable_next = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      load_enable_reg <= 1'b0;
    else
      load_enable_reg <= load_enable_next;
  end

  assign load_enable = load_enable_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Per-line pin logic

  // Two-stage synchroniser; first stage feeds only the second
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync_s1_reg <= '1;
      sync_s2_reg <= '1;
    end
    else
    begin
      sync_s1_reg <= sync_in;
      sync_s2_reg <= sync_s1_reg;
    end
  end

  generate
    for (genvar g = 0; g < NUM_LINES; g++)
    begin : g_line
      logic             inv;
      line_func_e       func;
      out_sel_e         osel;
      logic             act;
      logic             pwm_lvl;
      logic             out_lvl;
      logic [CNT_W-1:0] rx_cnt_reg;
      logic [CNT_W-1:0] tx_cnt_reg;
      logic [PWM_W-1:0] pwm_cnt_reg;

      assign inv  = cfg_reg[g][CFG_INV_BIT];
      assign func = line_func_e'(cfg_reg[g][CFG_FUNC_LSB +: 2]);
      assign osel = out_sel_e'(cfg_reg[g][CFG_OSEL_LSB +: 2]);
      // Low pin means logical 1 unless inverted
      assign act  = ~sync_s2_reg[g] ^ inv;

      // Width filter; own pulse is masked so it is not taken back
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          rx_cnt_reg <= '0;
        else if (func != FUNC_SYNC || tx_busy[g] || !act)
          rx_cnt_reg <= '0;
        else if (rx_cnt_reg != PULSE_CNT)
          rx_cnt_reg <= rx_cnt_reg + 1'b1;
      end

      // One accept per pulse, at the cycle the width is reached
      assign rx_accept[g] = (func == FUNC_SYNC) & act & ~tx_busy[g]
                            & (rx_cnt_reg == PULSE_CNT - 1'b1);

      // Pulse timer for the driven low phase
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          tx_cnt_reg <= '0;
        else if (tx_start[g] && func == FUNC_SYNC)
          tx_cnt_reg <= PULSE_CNT;
        else if (tx_cnt_reg != '0)
          tx_cnt_reg <= tx_cnt_reg - 1'b1;
      end

      assign tx_busy[g] = (tx_cnt_reg != '0);

      // Free-running PWM; period in clocks, duty as high clocks
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          pwm_cnt_reg <= '0;
        else if (pwm_cnt_reg + 1'b1 >= per_reg[g])
          pwm_cnt_reg <= '0;
        else
          pwm_cnt_reg <= pwm_cnt_reg + 1'b1;
      end

      assign pwm_lvl = (per_reg[g] != '0) & (pwm_cnt_reg < duty_reg[g]);

      always_comb
      begin
        case (osel)
          OSEL_TRUE: out_lvl = 1'b1;
          OSEL_PWM:  out_lvl = pwm_lvl;
          default:   out_lvl = 1'b0;
        endcase
      end

      // Pin drivers; sync lines only drive while pulsing, wired style
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          out_reg[g] <= 1'b1;
          oe_reg[g]  <= 1'b0;
        end
        else
        begin
          case (func)
            FUNC_SYNC:
            begin
              out_reg[g] <= inv;
              oe_reg[g]  <= tx_busy[g];
            end
            FUNC_OUTPUT:
            begin
              out_reg[g] <= ~out_lvl ^ inv;
              oe_reg[g]  <= 1'b1;
            end
            default:
            begin
              out_reg[g] <= 1'b1;
              oe_reg[g]  <= 1'b0;
            end
          endcase
        end
      end

      // Polarity-corrected level, readable in every mode
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          level_reg[g] <= 1'b0;
        else
          level_reg[g] <= act;
      end
    end
  endgenerate

  assign sync_out   = out_reg;
  assign sync_oe    = oe_reg;
  assign line_level = level_reg;

endmodule : sync_on_off_pulse_io
`default_nettype wire

// [dv/sync_io_monitor.sv]
`timescale 1ns/100ps
`default_nettype none
module sync_io_monitor
  import sync_io_pkg::*;
(
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic [31:0]       s_axi_wdata,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic [1:0]        sync_in,
  input wire logic [1:0]        sync_out,
  input wire logic [1:0]        sync_oe,
  input wire logic [1:0]        line_level,
  input wire logic              load_enable
);
  logic [7:0]  aw_a;
  logic [4:0]  wd, c0, c1;
  logic [3:0]  age;
  logic [10:0] n0, n1, r0, r1;
  logic        s0, s1, isc;
  assign s0  = (c0[2:1] == FUNC_SYNC);
  assign s1  = (c1[2:1] == FUNC_SYNC);
  assign isc = (aw_a == ADDR_CFG0) || (aw_a == ADDR_CFG1);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////
  // Shadow of line setup; age blanks checks while a setup write settles
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      c0  <= CFG_RST;
      c1  <= CFG_RST;
      age <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
        aw_a <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready)
        wd <= s_axi_wdata[4:0];
      if ($rose(s_axi_bvalid) && aw_a == ADDR_CFG0)
        c0 <= wd;
      if ($rose(s_axi_bvalid) && aw_a == ADDR_CFG1)
        c1 <= wd;
      if (($rose(s_axi_bvalid) && isc) || (s_axi_awvalid && s_axi_awready &&
          (s_axi_awaddr == ADDR_CFG0 || s_axi_awaddr == ADDR_CFG1)))
        age <= 4'h0;
      else if (age != 4'hF)
        age <= age + 4'h1;
    end
  end
  // Run lengths of own drive and of received active phases
  always_ff @(posedge aclk)
  begin
    n0 <= sync_oe[0] ? n0 + 11'h1 : 11'h0;
    n1 <= sync_oe[1] ? n1 + 11'h1 : 11'h0;
    if ((~sync_in[0] ^ c0[0]) && !sync_oe[0] && s0)
      r0 <= (r0 == 11'h7FF) ? r0 : r0 + 11'h1;
    else
      r0 <= 11'h0;
    if ((~sync_in[1] ^ c1[0]) && !sync_oe[1] && s1)
      r1 <= (r1 == 11'h7FF) ? r1 : r1 + 11'h1;
    else
      r1 <= 11'h0;
  end
  ////////////////////////////////////////////////////////////////////////////
  a_tx_width_on: assert property ($fell(sync_oe[0]) && s0 && age == 4'hF
    |-> n0 == 11'(PULSE_CYC)) else $error("turn-on pulse width wrong");
  a_tx_width_off: assert property ($fell(sync_oe[1]) && s1
    && age == 4'hF |-> n1 == 11'(PULSE_CYC))
    else $error("turn-off pulse width wrong");
  a_on_emits: assert property ($rose(sync_oe[0]) && s0 && age == 4'hF
    |-> load_enable && !$past(load_enable, 2)) else $error("stray on pulse");
  a_off_emits: assert property ($rose(sync_oe[1]) && s1 && age == 4'hF
    |-> !load_enable && $past(load_enable, 2)) else $error("stray off pulse");
  a_rx_turn_on: assert property (r0 == 11'd612 |-> ##[0:2] load_enable)
    else $error("received on pulse ignored");
  a_rx_turn_off: assert property (r1 == 11'd612 |-> !load_enable)
    else $error("received off pulse ignored");
  a_rx_on_width: assert property ($rose(load_enable)
    && !$rose(s_axi_bvalid) |-> $past(r0, 4) >= 11'd590)
    else $error("on pulse taken too short");
  a_rx_off_width: assert property ($fell(load_enable)
    && !$rose(s_axi_bvalid) |-> $past(r1, 4) >= 11'd590)
    else $error("off pulse taken too short");
  a_out_static: assert property (age == 4'hF
    && c1[2:1] == FUNC_OUTPUT && c1[4:3] != OSEL_PWM |-> sync_oe[1]
    && sync_out[1] == ((c1[4:3] != OSEL_TRUE) ^ c1[0]))
    else $error("static drive wrong");
  a_in_level: assert property (age == 4'hF |-> line_level[0] ==
    (!$past(sync_in[0], 3) ^ c0[0])) else $error("input level wrong");
  c_on: cover property ($rose(load_enable));
  c_off: cover property ($fell(load_enable));
  c_tx: cover property ($fell(sync_oe[0]));
endmodule : sync_io_monitor
`default_nettype wire

// [dv/sync_on_off_pulse_io_test.sv]
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fails++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module sync_on_off_pulse_io_test;
  import sync_io_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
  logic load_enable;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd_v, seed = 32'hBF489CEE;
  logic [1:0]  bresp, rresp, rr, pgo = 2'h0, phold = 2'h0, o;
  logic [1:0]  sync_out, sync_oe, line_level, plow;
  logic [10:0] plen = 11'h0;
  logic [7:0]  seen [2];
  wire  [1:0]  pin = ~((sync_oe & ~sync_out) | plow);
  int          fails = 0, samples_checked = 0, cyc = 0, k, lows;
  always #25 aclk = ~aclk;
  sync_on_off_pulse_io dut_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sync_in(pin),
    .sync_out(sync_out), .sync_oe(sync_oe), .line_level(line_level),
    .load_enable(load_enable));
  sync_partner part_u (.aclk(aclk), .aresetn(aresetn), .pin(pin), .go(pgo),
    .hold(phold), .len(plen), .low(plow), .seen(seen));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Pin level of a static output: a logical 1 pulls low unless inverted
  function automatic logic exp_pin(input logic [1:0] os, input logic inv);
    return (os != OSEL_TRUE) ^ inv;
  endfunction : exp_pin
  task automatic print_verdict();
    $display("fails=%0d samples_checked=%0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
    end while (!bvalid);
    rr = bresp;
    bready <= 0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 0;
    end while (!rvalid);
    rd_v = rdata;
    rr = rresp;
    rready <= 0;
  endtask : rd
  // Partner pulse on one line, then room for the answer to land
  task automatic pulse(input int i, input int n);
    @(posedge aclk);
    pgo <= 2'b01 << i; plen <= 11'(n);
    @(posedge aclk);
    pgo <= 2'b00;
    repeat (n + 20) @(posedge aclk);
  endtask : pulse
  // Hang guard
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      fails++;
      print_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    rd(ADDR_CFG0); `CHK(rd_v, 32'h0)
    rd(ADDR_CFG1); `CHK(rd_v, 32'h0)
    rd(ADDR_CTRL); `CHK(rd_v[0], 1'b0)
    rd(8'h20); `CHK(rr, RESP_SLVERR)
    wr(8'h24, 32'h1); `CHK(rr, RESP_SLVERR)
    // Local on and off send one pulse each on their own line
    wr(ADDR_CTRL, 32'h1); `CHK(load_enable, 1'b1)
    rd(ADDR_STATUS); `CHK(rd_v[4:3], 2'b01)
    repeat (700) @(posedge aclk);
    `CHK(seen[0], 8'h1)
    pulse(0, 650); `CHK(load_enable, 1'b1)
    wr(ADDR_CTRL, 32'h2); `CHK(load_enable, 1'b0)
    rd(ADDR_STATUS); `CHK(rd_v[4:3], 2'b10)
    repeat (700) @(posedge aclk);
    `CHK(seen[1], 8'h1)
    pulse(1, 650); `CHK(load_enable, 1'b0)
    pulse(0, 550); `CHK(load_enable, 1'b0)
    seed = lfsr(seed);
    pulse(0, 620 + seed[5:0]); `CHK(load_enable, 1'b1)
    rd(ADDR_STATUS); `CHK(rd_v[0], 1'b1)
    seed = lfsr(seed);
    pulse(1, 620 + seed[5:0]); `CHK(load_enable, 1'b0)
    `CHK(seen[0], 8'h1)
    // General input with random polarity and level
    for (k = 0; k < 8; k++)
    begin
      seed = lfsr(seed);
      wr(ADDR_CFG0, {27'h0, OSEL_FALSE, FUNC_INPUT, seed[0]});
      phold <= {1'b0, seed[1]};
      repeat (6) @(posedge aclk);
      `CHK(line_level[0], seed[1] ^ seed[0])
    end
    // Static outputs for both values and both polarities
    for (k = 0; k < 4; k++)
    begin
      o = k[1] ? OSEL_TRUE : OSEL_FALSE;
      wr(ADDR_CFG1, {27'h0, o, FUNC_OUTPUT, k[0]});
      repeat (4) @(posedge aclk);
      `CHK(pin[1], exp_pin(o, k[0]))
    end
    // PWM, period 4: one logical 1 clock on line 1, three on line 0
    phold <= 2'b00;
    wr(ADDR_PER0, 32'h4);
    wr(ADDR_DUTY0, 32'h3);
    rd(ADDR_DUTY0); `CHK(rd_v, 32'h3)
    wr(ADDR_CFG0, {27'h0, OSEL_PWM, FUNC_OUTPUT, 1'b0});
    wr(ADDR_PER1, 32'h4);
    wr(ADDR_DUTY1, 32'h1);
    wr(ADDR_CFG1, {27'h0, OSEL_PWM, FUNC_OUTPUT, 1'b0});
    repeat (8) @(posedge aclk);
    lows = 0;
    k = 0;
    repeat (8)
    begin
      @(posedge aclk);
      lows += (pin[1] === 1'b0);
      k += (pin[0] === 1'b0);
    end
    `CHK(lows, 2)
    `CHK(k, 6)
    print_verdict();
  end
endmodule : sync_on_off_pulse_io_test
bind sync_on_off_pulse_io sync_io_monitor mon_u (.aclk(aclk),
  .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .sync_in(sync_in), .sync_out(sync_out), .sync_oe(sync_oe),
  .line_level(line_level), .load_enable(load_enable));
`default_nettype wire

// [dv/sync_partner.sv]
`timescale 1ns/100ps
`default_nettype none
module sync_partner
  import sync_io_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [1:0]  pin,
  input wire logic [1:0]  go,
  input wire logic [1:0]  hold,
  input wire logic [10:0] len,
  output logic [1:0]      low,
  output logic [7:0]      seen [2]
);
  logic [10:0] left [2];
  logic [10:0] run [2];
  // Own pulses; the bench asks for one 550-clock pulse below the minimum width, the rest at or above it
  assign low = hold | {left[1] != 11'h0, left[0] != 11'h0};
  ////////////////////////////////////////////////////////////////////////////
  // Count pulses from the far end that are wide enough to be taken
  always_ff @(posedge aclk)
  begin
    for (int i = 0; i < 2; i++)
    begin
      if (!aresetn)
      begin
        left[i] <= 11'h0;
        run[i]  <= 11'h0;
        seen[i] <= 8'h0;
      end
      else
      begin
        left[i] <= go[i] ? len : (left[i] != 11'h0 ? left[i] - 11'h1 : 11'h0);
        run[i]  <= (!pin[i] && !low[i] && run[i] != 11'h7FF) ?
                   run[i] + 11'h1 : (pin[i] ? 11'h0 : run[i]);
        if (pin[i] && run[i] >= 11'(PULSE_CYC))
          seen[i] <= seen[i] + 8'h1;
      end
    end
  end
endmodule : sync_partner
`default_nettype wire
